// ### include/rgbpm_pkg.sv
// Constants shared by the RGB channel PWM mixer
// How it works
// - Every channel has its own writable 8-bit colour level.
// - Channels 3m to 3m+2 share module m's intensity.
// - Each module intensity has 256 steps.
// - Intensity resets to ff, and ff means full scaling.
// - One global bit picks log or linear intensity; colour is never curved.
// - Duty is colour times curved intensity.
// - Duty is 12 bits: 9-bit PWM compare plus 3-bit dither.
// - Dither lengthens one pulse in eight per dither unit by one step.
// - Dither enable resets on; cleared gives plain 9-bit duty.
// - Every channel switches at 29 kHz.
// - Channels 3k are left aligned: fixed rise, moving fall.
// - Channels 3k+1 are centre aligned around a fixed midpoint.
// - Channels 3k+2 are right aligned: fixed fall, moving rise.
// - Group-follow select per module resets to 0, own settings.
// - Under group control shared colour and intensity replace own ones.
// - Group path uses the same product and PWM generation.
// - Channel index mod 3 picks group A, B, C; 24 or 18 outputs.
// - Peak-current bit: 0 selects 25.5 mA, 1 selects 35 mA.
// - Run bit cleared holds sinks off; settings stay accessible.
package rgbpm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned PWM_HZ = 29_000;
  localparam int unsigned PERIOD_CYC = CLOCK_HZ / PWM_HZ;
  localparam logic [8:0] PERIOD_LEN = 9'(PERIOD_CYC);
  localparam logic [8:0] PERIOD_LAST = 9'(PERIOD_CYC - 1);
  // ----------------------------------------
  // Duty layout
  // ----------------------------------------
  localparam int DUTY_MSB = 15;
  localparam int DUTY_LSB = 4;
  localparam int PWM_BITS = 9;
  localparam int DITH_BITS = 3;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_FOLLOW = 8'h01;
  localparam logic [7:0] ADDR_BANK_A = 8'h02;
  localparam logic [7:0] ADDR_BANK_B = 8'h03;
  localparam logic [7:0] ADDR_BANK_C = 8'h04;
  localparam logic [7:0] ADDR_BANK_INT = 8'h05;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_INT_BASE = 8'h08;
  localparam logic [7:0] ADDR_COLOR_BASE = 8'h10;
  // ----------------------------------------
  // Config fields and reset values
  // ----------------------------------------
  localparam int CFG_RUN = 0;
  localparam int CFG_LOG = 1;
  localparam int CFG_DITHER = 2;
  localparam int CFG_PEAK = 3;
  localparam logic RUN_RESET = 1'b0;
  localparam logic LOG_RESET = 1'b1;
  localparam logic DITHER_RESET = 1'b1;
  localparam logic PEAK_RESET = 1'b0;
  localparam logic [7:0] FOLLOW_RESET = 8'h00;
  localparam logic [7:0] COLOR_RESET = 8'h00;
  localparam logic [7:0] INTENSITY_RESET = 8'hff;
endpackage : rgbpm_pkg

// ### verilog/rgbpm_chan.sv
// One PWM output channel with dither and phase alignment
`timescale 1ns/100ps
`default_nettype none
module rgbpm_chan
  import rgbpm_pkg::*;
#(
  parameter int PHASE = 0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrap,
  input wire logic [8:0] count,
  input wire logic [2:0] slot,
  input wire logic dither_en,
  input wire logic run,
  input wire logic [15:0] product,
  output logic sink
);
  logic [8:0] len_reg;
  logic [8:0] len_next;
  logic [8:0] start;
  logic [11:0] duty;
  logic [17:0] scaled;
  logic [9:0] stop;
  logic on;

  // ----------------------------------------
  // Pulse length for the coming period
  // ----------------------------------------
  always_comb begin
    duty = product[DUTY_MSB:DUTY_LSB];
    scaled = 18'(duty[11:DITH_BITS]) * 18'(PERIOD_CYC);
    len_next = scaled[17:PWM_BITS];
    if (dither_en && (slot < duty[DITH_BITS-1:0])) begin
      len_next = len_next + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      len_reg <= 9'h000;
    end else if (wrap) begin
      len_reg <= len_next;
    end
  end

  // ----------------------------------------
  // Alignment
  // ----------------------------------------
  always_comb begin
    if (PHASE == 0) begin
      start = 9'h000;
    end else if (PHASE == 1) begin
      start = (PERIOD_LEN - len_reg) >> 1;
    end else begin
      start = PERIOD_LEN - len_reg;
    end
    stop = {1'b0, start} + {1'b0, len_reg};
    on = (count >= start) && ({1'b0, count} < stop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sink <= 1'b0;
    end else begin
      sink <= run && on;
    end
  end
endmodule : rgbpm_chan
`default_nettype wire

// ### verilog/rgbpm_top.sv
// Register file, colour and intensity mixing and PWM timebase
`timescale 1ns/100ps
`default_nettype none
module rgbpm_top
  import rgbpm_pkg::*;
#(
  parameter int NUM_CHANNELS = 24
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [7:0] RDATA,
  output logic PEAK_CURRENT_SEL,
  output logic [NUM_CHANNELS-1:0] SINK_OUTPUT
);
  localparam int NUM_MODULES = NUM_CHANNELS / 3;
  localparam logic [7:0] NCH = 8'(NUM_CHANNELS);
  localparam logic [7:0] NMOD = 8'(NUM_MODULES);
  localparam int CH_W = $clog2(NUM_CHANNELS);
  localparam int MOD_W = $clog2(NUM_MODULES);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] curve(
    input logic [7:0] v,
    input logic log_on
  );
    logic [12:0] t;
    t = 13'({1'b1, v[4:0]}) << v[7:5];
    if (!log_on || v == 8'hff || v == 8'h00) begin
      curve = v;
    end else begin
      curve = t[12:5];
    end
  endfunction : curve

  function automatic logic in_window(
    input logic [7:0] a,
    input logic [7:0] base,
    input logic [7:0] n
  );
    in_window = (a >= base) && ((a - base) < n);
  endfunction : in_window

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic run_reg;
  logic log_reg;
  logic dither_reg;
  logic peak_reg;
  logic [7:0] follow_reg;
  logic [7:0] bank_color_reg [3];
  logic [7:0] bank_int_reg;
  logic [7:0] module_intensity_reg [NUM_MODULES];
  logic [7:0] channel_color_level_reg [NUM_CHANNELS];
  logic [7:0] rdata_next;
  logic [7:0] chan_idx;
  logic [7:0] mod_idx;
  logic wr_color;
  logic wr_int;

  assign chan_idx = ADDR - ADDR_COLOR_BASE;
  assign mod_idx = ADDR - ADDR_INT_BASE;
  assign wr_color = WRITE && in_window(ADDR, ADDR_COLOR_BASE, NCH);
  assign wr_int = WRITE && in_window(ADDR, ADDR_INT_BASE, NMOD);

  // Global configuration
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      run_reg <= RUN_RESET;
      log_reg <= LOG_RESET;
      dither_reg <= DITHER_RESET;
      peak_reg <= PEAK_RESET;
    end else if (WRITE && ADDR == ADDR_CONFIG) begin
      run_reg <= WDATA[CFG_RUN];
      log_reg <= WDATA[CFG_LOG];
      dither_reg <= WDATA[CFG_DITHER];
      peak_reg <= WDATA[CFG_PEAK];
    end
  end

  // Group follow selects
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      follow_reg <= FOLLOW_RESET;
    end else if (WRITE && ADDR == ADDR_FOLLOW) begin
      follow_reg <= WDATA;
    end
  end

  // Shared group settings
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int i = 0; i < 3; i++) begin
        bank_color_reg[i] <= COLOR_RESET;
      end
      bank_int_reg <= INTENSITY_RESET;
    end else if (WRITE) begin
      if (ADDR == ADDR_BANK_A) begin
        bank_color_reg[0] <= WDATA;
      end
      if (ADDR == ADDR_BANK_B) begin
        bank_color_reg[1] <= WDATA;
      end
      if (ADDR == ADDR_BANK_C) begin
        bank_color_reg[2] <= WDATA;
      end
      if (ADDR == ADDR_BANK_INT) begin
        bank_int_reg <= WDATA;
      end
    end
  end

  // Module intensities
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        module_intensity_reg[i] <= INTENSITY_RESET;
      end
    end else if (wr_int) begin
      module_intensity_reg[mod_idx[MOD_W-1:0]] <= WDATA;
    end
  end

  // Channel colour levels
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        channel_color_level_reg[i] <= COLOR_RESET;
      end
    end else if (wr_color) begin
      channel_color_level_reg[chan_idx[CH_W-1:0]] <= WDATA;
    end
  end

  // ----------------------------------------
  // PWM timebase
  // ----------------------------------------
  logic [8:0] cnt_reg;
  logic [2:0] slot_reg;
  logic [2:0] slot_next;
  logic wrap;

  assign wrap = (cnt_reg == PERIOD_LAST);
  assign slot_next = slot_reg + 3'h1;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cnt_reg <= 9'h000;
    end else if (wrap) begin
      cnt_reg <= 9'h000;
    end else begin
      cnt_reg <= cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      slot_reg <= 3'h0;
    end else if (wrap) begin
      slot_reg <= slot_next;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    unique case (ADDR)
      ADDR_CONFIG: begin
        rdata_next[CFG_RUN] = run_reg;
        rdata_next[CFG_LOG] = log_reg;
        rdata_next[CFG_DITHER] = dither_reg;
        rdata_next[CFG_PEAK] = peak_reg;
      end
      ADDR_FOLLOW: rdata_next = follow_reg;
      ADDR_BANK_A: rdata_next = bank_color_reg[0];
      ADDR_BANK_B: rdata_next = bank_color_reg[1];
      ADDR_BANK_C: rdata_next = bank_color_reg[2];
      ADDR_BANK_INT: rdata_next = bank_int_reg;
      ADDR_STATUS: rdata_next = {run_reg, 4'h0, slot_reg};
      default: begin
        if (in_window(ADDR, ADDR_COLOR_BASE, NCH)) begin
          rdata_next = channel_color_level_reg[chan_idx[CH_W-1:0]];
        end else if (in_window(ADDR, ADDR_INT_BASE, NMOD)) begin
          rdata_next = module_intensity_reg[mod_idx[MOD_W-1:0]];
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (READ) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= 8'h00;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      PEAK_CURRENT_SEL <= PEAK_RESET;
    end else begin
      PEAK_CURRENT_SEL <= peak_reg;
    end
  end

  // ----------------------------------------
  // Mixing and channel generators
  // ----------------------------------------
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    localparam int MOD = ch / 3;
    localparam int GRP = ch % 3;
    logic [7:0] color;
    logic [7:0] level;
    logic [15:0] product;

    always_comb begin
      if (follow_reg[MOD]) begin
        color = bank_color_reg[GRP];
        level = curve(bank_int_reg, log_reg);
      end else begin
        color = channel_color_level_reg[ch];
        level = curve(module_intensity_reg[MOD], log_reg);
      end
      product = 16'(color) * 16'(level);
    end

    rgbpm_chan #(
      .PHASE(GRP)
    ) u_chan (
      .clk(CLOCK),
      .rst(RESET),
      .wrap(wrap),
      .count(cnt_reg),
      .slot(slot_next),
      .dither_en(dither_reg),
      .run(run_reg),
      .product(product),
      .sink(SINK_OUTPUT[ch])
    );
  end
endmodule : rgbpm_top
`default_nettype wire

// ### testbench/rgbpm_props.sv
// Port assertions for the RGB channel PWM mixer
`timescale 1ns/100ps
`default_nettype none
module rgbpm_props
  import rgbpm_pkg::*;
#(
  parameter int NUM_CHANNELS = 24
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  input wire logic [7:0] RDATA,
  input wire logic PEAK_CURRENT_SEL,
  input wire logic [NUM_CHANNELS-1:0] SINK_OUTPUT
);
  localparam logic [7:0] COLOR_END = 8'(ADDR_COLOR_BASE + NUM_CHANNELS);
  localparam logic [7:0] INT_END = 8'(ADDR_INT_BASE + NUM_CHANNELS / 3);
  logic run_q;
  logic seen_l;
  logic seen_r;
  logic [8:0] gap_l;
  logic [8:0] gap_r;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  // Run bit mirror and period phase trackers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      run_q <= RUN_RESET;
      seen_l <= 1'b0;
      seen_r <= 1'b0;
      gap_l <= 9'h000;
      gap_r <= 9'h000;
    end else begin
      if (WRITE && ADDR == ADDR_CONFIG) begin
        run_q <= WDATA[CFG_RUN];
      end
      seen_l <= seen_l | ($rose(SINK_OUTPUT[0]) && $past(run_q, 2));
      seen_r <= seen_r | ($fell(SINK_OUTPUT[2]) && $past(run_q));
      gap_l <= ($rose(SINK_OUTPUT[0]) && $past(run_q, 2)) ? 9'h001 :
        (gap_l == PERIOD_LAST ? 9'h000 : gap_l + 9'h001);
      gap_r <= ($fell(SINK_OUTPUT[2]) && $past(run_q)) ? 9'h001 :
        (gap_r == PERIOD_LAST ? 9'h000 : gap_r + 9'h001);
    end
  end
  sequence s_cfg_wr;
    WRITE && ADDR == ADDR_CONFIG;
  endsequence
  property p_rd_idle;
    !$past(READ) |-> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_cfg;
    logic [7:0] d;
    (s_cfg_wr, d = WDATA) ##[1:2] (READ && ADDR == ADDR_CONFIG) |=> RDATA == {4'h0, d[3:0]};
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config readback wrong");
  property p_rd_color;
    logic [7:0] a, d;
    (WRITE && ADDR >= ADDR_COLOR_BASE && ADDR < COLOR_END, a = ADDR, d = WDATA)
      ##[1:2] (READ && ADDR == a) |=> RDATA == d;
  endproperty
  a_rd_color: assert property (p_rd_color) else $error("colour readback wrong");
  property p_rd_int;
    logic [7:0] a, d;
    (WRITE && ADDR >= ADDR_INT_BASE && ADDR < INT_END, a = ADDR, d = WDATA)
      ##[1:2] (READ && ADDR == a) |=> RDATA == d;
  endproperty
  a_rd_int: assert property (p_rd_int) else $error("intensity readback wrong");
  property p_peak;
    s_cfg_wr |=> ##1 PEAK_CURRENT_SEL == $past(WDATA[CFG_PEAK], 2);
  endproperty
  a_peak: assert property (p_peak) else $error("peak select not following");
  property p_run_off;
    !$past(run_q) && !run_q |-> SINK_OUTPUT == '0;
  endproperty
  a_run_off: assert property (p_run_off) else $error("sink on while stopped");
  property p_left_rise;
    $rose(SINK_OUTPUT[0]) && seen_l && $past(run_q, 2) |-> gap_l == 9'h000;
  endproperty
  a_left_rise: assert property (p_left_rise) else $error("left rise moved");
  property p_right_fall;
    $fell(SINK_OUTPUT[2]) && seen_r && $past(run_q) |-> gap_r == 9'h000;
  endproperty
  a_right_fall: assert property (p_right_fall) else $error("right fall moved");
endmodule : rgbpm_props
`default_nettype wire

// ### testbench/rgbpm_leds.sv
// LED modules that add up each sink's on time
`timescale 1ns/100ps
`default_nettype none
module rgbpm_leds #(
  parameter int N = 24
) (
  input wire logic clk,
  input wire logic clear,
  input wire logic [N-1:0] sink
);
  logic [15:0] lit [N];
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      lit[i] <= clear ? 16'h0000 : lit[i] + 16'(sink[i]);
    end
  end
endmodule : rgbpm_leds
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the RGB channel PWM mixer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rgbpm_pkg::*;
  localparam int NCH = 24;
  localparam logic [7:0] RST_A [7] = '{8'h00, 8'h01, 8'h05, 8'h08, 8'h10, 8'h07, 8'h06};
  localparam logic [7:0] RST_V [7] = '{8'h06, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic write = 1'b0;
  logic read = 1'b0;
  logic clear = 1'b0;
  logic [7:0] rdata;
  logic peak;
  logic [NCH-1:0] sink;
  int mismatches = 0;
  int n_compared = 0;
  always #50 clock = ~clock;
  rgbpm_top #(.NUM_CHANNELS(NCH)) dut (.CLOCK(clock), .RESET(reset), .ADDR(addr),
    .WDATA(wdata), .WRITE(write), .READ(read), .RDATA(rdata), .PEAK_CURRENT_SEL(peak),
    .SINK_OUTPUT(sink));
  rgbpm_leds #(.N(NCH)) leds (.clk(clock), .clear(clear), .sink(sink));
  // ----------------------------------------
  // Bus and measurement tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
    @(negedge clock);
    check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
  endtask : rd
  task automatic measure(input int ch, input logic [7:0] c, input logic [7:0] lvl, input bit dth);
    logic [15:0] p;
    logic [15:0] len;
    p = c * lvl;
    len = 16'((int'(p[15:7]) * int'(PERIOD_CYC)) / 512);
    repeat (2 * PERIOD_CYC) @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (8 * PERIOD_CYC) @(posedge clock);
    @(negedge clock);
    check($sformatf("sink %0d on time", ch), 16'(8 * len) + (dth ? 16'(p[6:4]) : 16'h0000),
      leds.lit[ch]);
  endtask : measure
  task automatic wrap_up;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check("peak", 16'h0000, {15'h0000, peak});
    foreach (RST_A[i]) rd(RST_A[i], RST_V[i]);
    wr(8'h10, 8'h81);
    wr(8'h11, 8'h81);
    wr(8'h12, 8'h81);
    wr(8'h00, 8'h05);
    measure(0, 8'h81, 8'hff, 1'b1);
    wr(8'h00, 8'h01);
    measure(0, 8'h81, 8'hff, 1'b0);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'hff);
    wr(8'h08, 8'h40);
    rd(8'h08, 8'h40);
    wr(8'h00, 8'h05);
    measure(0, 8'hff, 8'h40, 1'b1);
    wr(8'h00, 8'h07);
    measure(0, 8'hff, 8'h04, 1'b1);
    wr(8'h09, 8'h00);
    wr(8'h13, 8'hff);
    measure(3, 8'hff, 8'h00, 1'b1);
    measure(2, 8'h81, 8'h04, 1'b1);
    wr(8'h02, 8'h81);
    wr(8'h03, 8'h40);
    wr(8'h05, 8'hff);
    wr(8'h01, 8'h01);
    measure(0, 8'h81, 8'hff, 1'b1);
    measure(1, 8'h40, 8'hff, 1'b1);
    wr(8'h00, 8'h0f);
    rd(8'h00, 8'h0f);
    check("peak", 16'h0001, {15'h0000, peak});
    wr(8'h00, 8'h0e);
    measure(0, 8'h00, 8'h00, 1'b1);
    rd(8'h10, 8'hff);
    wrap_up();
  end
endmodule : tb
bind rgbpm_top rgbpm_props #(.NUM_CHANNELS(NUM_CHANNELS)) u_props (.CLOCK(CLOCK),
  .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA),
  .PEAK_CURRENT_SEL(PEAK_CURRENT_SEL), .SINK_OUTPUT(SINK_OUTPUT));
`default_nettype wire
